// ===== rtl/cisbc_params.svh
/*
 * constants for the interrupt / serial / bus control block: bit positions,
 * vectors, reset values.
 * assumes inclusion by bare name from rtl files.
 */
`ifndef CISBC_PARAMS_SVH
`define CISBC_PARAMS_SVH

// mask-set accumulator layout
`define CISBC_SET_SERIAL_DATA 7
`define CISBC_SET_SERIAL_EN 6
`define CISBC_SET_RESET_75 4
`define CISBC_SET_MASK_EN 3
// mask-read layout
`define CISBC_RD_SERIAL_IN 7
`define CISBC_RD_PEND_HI 6
`define CISBC_RD_PEND_LO 4
`define CISBC_RD_IE 3
// restart vectors
`define CISBC_VEC_NMI 8'h24
`define CISBC_VEC_75 8'h3C
`define CISBC_VEC_65 8'h34
`define CISBC_VEC_55 8'h2C
`define CISBC_VEC_NONE 8'h00
// reset values
`define CISBC_MASK_RST 3'h7
`define CISBC_START_ADDR 16'h0000
// status codes {high, low}
`define CISBC_ST_HALT 2'h0
`define CISBC_ST_WRITE 2'h1
`define CISBC_ST_READ 2'h2
`define CISBC_ST_FETCH 2'h3

`endif

// ===== rtl/cisbc_pkg.sv
/*
 * types shared by the control block and its flag unit.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package cisbc_pkg;

	typedef enum logic [1:0] {
		CISBC_CYC_HALT = 2'h0,
		CISBC_CYC_WRITE = 2'h1,
		CISBC_CYC_READ = 2'h2,
		CISBC_CYC_FETCH = 2'h3
	} cisbc_cycle_t;

	typedef enum logic [2:0] {
		CISBC_SRC_NONE = 3'h0,
		CISBC_SRC_NMI = 3'h1,
		CISBC_SRC_R75 = 3'h2,
		CISBC_SRC_R65 = 3'h3,
		CISBC_SRC_R55 = 3'h4,
		CISBC_SRC_GEN = 3'h5
	} cisbc_src_t;

	typedef struct packed {
		logic sign;
		logic zero;
		logic aux_carry;
		logic parity;
		logic carry;
	} cisbc_flags_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] data;
		logic rd_n;
		logic wr_n;
		logic io_m;
	} cisbc_bus_t;

endpackage : cisbc_pkg

// ===== rtl/cisbc_flags.sv
/*
 * flag unit: registers sign, zero, parity, carry and auxiliary carry from an
 * 8-bit add or subtract, and evaluates branch conditions.
 * assumes operands and strobe come from logic on core_clk.
 */
`timescale 1ns/1ps
`include "cisbc_params.svh"

module cisbc_flags
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic alu_update,
	input wire logic alu_sub,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic alu_cin,
	input wire logic [2:0] cond_sel,
	output cisbc_pkg::cisbc_flags_t flags,
	output logic [7:0] alu_result,
	output logic cond_true
);

	cisbc_pkg::cisbc_flags_t flags_reg;
	cisbc_pkg::cisbc_flags_t flags_next;
	logic [7:0] b_eff;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] res_reg;

	always_comb
	begin
		b_eff = alu_sub ? ~alu_b : alu_b;
		sum = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, alu_sub ^ alu_cin};
		nib = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_sub ^ alu_cin};
		flags_next.sign = sum[7];
		flags_next.zero = (sum[7:0] == 8'h00);
		flags_next.parity = ~(^sum[7:0]);
		flags_next.carry = sum[8] ^ alu_sub;
		flags_next.aux_carry = nib[4] ^ alu_sub;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			flags_reg <= '0;
			res_reg <= 8'h00;
		end
		else if (clk_en && alu_update)
		begin
			flags_reg <= flags_next;
			res_reg <= sum[7:0];
		end
	end

	// condition select: 0 nz,1 z,2 nc,3 c,4 po,5 pe,6 p,7 m
	always_comb
	begin
		unique case (cond_sel[2:1])
			2'h0: cond_true = flags_reg.zero;
			2'h1: cond_true = flags_reg.carry;
			2'h2: cond_true = flags_reg.parity;
			2'h3: cond_true = flags_reg.sign;
		endcase
		if (!cond_sel[0])
			cond_true = ~cond_true;
	end

	assign flags = flags_reg;
	assign alu_result = res_reg;

endmodule : cisbc_flags

// ===== rtl/cisbc_ctrl.sv
/*
 * control block of an 8-bit processor: prioritised interrupts with vectors,
 * mask-set / mask-read handling with a one-bit serial port, bus status codes,
 * bus hold for dma, clock division and flag evaluation.
 * assumes instruction decode and datapath drive the strobes from core_clk;
 * interrupt, hold and serial pins are asynchronous and synchronised here.
 */
// Contract
// - float bus strobes, address, data while granted
// - bus request answered by bus grant
// - internal clock is crystal divided by two
// - status codes halt, write, read, fetch at latch
// - five interrupt inputs, three maskable restarts
// - fixed priority and restart vectors
// - level restarts; 7.5 edge latched
// - nonmaskable ignores masks and enable
// - nonmaskable needs new rising edge each time
// - mask-read loads masks and serial input
// - enable kept across nonmaskable for mask-read
// - mask-set programs masks and serial output
// - mask-set enables gate masks and serial; bit 4 alone resets the 7.5 latch
// - sign flag from bit 7
// - zero flag on zero result
// - parity flag on even parity
// - carry flag from bit 7 carry/borrow
// - auxiliary carry from bit 3 to 4
// - conditions use last flag results
// - mask-read puts serial input in bit 7
// - serial output holds last enabled write
// - general request: hold pc, acknowledge, read instruction
// - reset starts at 0, clears enable and grant
`timescale 1ns/1ps
`include "cisbc_params.svh"

module cisbc_ctrl
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	output logic clk_out,
	input wire logic nmi_in,
	input wire logic restart_75_in,
	input wire logic restart_65_in,
	input wire logic restart_55_in,
	input wire logic general_interrupt_request,
	input wire logic int_poll,
	input wire logic int_enable_set,
	input wire logic int_enable_clr,
	output logic int_take,
	output logic [7:0] int_vector,
	output logic int_ack_n,
	input wire logic int_ack_done,
	output logic hold_pc,
	output logic [15:0] start_addr,
	input wire logic mask_read_instruction,
	input wire logic mask_set_instruction,
	input wire logic [7:0] working_register_a,
	output logic [7:0] mask_read_data,
	input wire logic serial_input_bit,
	output logic serial_output_bit,
	input wire logic bus_request,
	input wire logic cycle_end,
	output logic bus_grant_out,
	input wire logic latch_strobe,
	input wire cisbc_pkg::cisbc_cycle_t cycle_kind,
	output logic status_code_high,
	output logic status_code_low,
	input wire cisbc_pkg::cisbc_bus_t bus_drive,
	output cisbc_pkg::cisbc_bus_t bus_out,
	output logic bus_oe,
	output logic [7:0] bus_data_oe,
	input wire logic alu_update,
	input wire logic alu_sub,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic alu_cin,
	input wire logic [2:0] cond_sel,
	output cisbc_pkg::cisbc_flags_t flags,
	output logic [7:0] alu_result,
	output logic cond_true
);

	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	logic nmi_s;
	logic r75_s;
	logic r65_s;
	logic r55_s;
	logic gen_s;
	logic sid_s;
	logic hold_s;

	assign pin_raw = {bus_request, serial_input_bit, general_interrupt_request,
		restart_55_in, restart_65_in, restart_75_in, nmi_in};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1)
		begin : g_sync
			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
				begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end
				else if (clk_en)
				begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	assign nmi_s = sync2_reg[0];
	assign r75_s = sync2_reg[1];
	assign r65_s = sync2_reg[2];
	assign r55_s = sync2_reg[3];
	assign gen_s = sync2_reg[4];
	assign sid_s = sync2_reg[5];
	assign hold_s = sync2_reg[6];

	// ***************************************************************
	// clock divider
	// ***************************************************************
	logic clk_div_reg;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			clk_div_reg <= 1'b0;
		else if (clk_en)
			clk_div_reg <= ~clk_div_reg;
	end

	assign clk_out = clk_div_reg;

	// ***************************************************************
	// edge capture for 7.5 and nonmaskable
	// ***************************************************************
	logic r75_prev_reg;
	logic r75_latch_reg;
	logic nmi_prev_reg;
	logic nmi_pend_reg;
	logic nmi_armed_reg;
	logic ie_reg;
	logic ie_saved_reg;
	logic [2:0] mask_reg;
	logic sod_reg;
	logic nmi_go;
	logic r75_go;
	logic r65_go;
	logic r55_go;
	logic gen_go;
	logic set_clears_75;
	cisbc_pkg::cisbc_src_t src;

	assign set_clears_75 = mask_set_instruction
		&& working_register_a[`CISBC_SET_RESET_75];

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			r75_prev_reg <= 1'b0;
			r75_latch_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			r75_prev_reg <= r75_s;
			// a rising edge in the clearing cycle still sets the latch
			if (r75_s && !r75_prev_reg)
				r75_latch_reg <= 1'b1;
			else if (set_clears_75 || (int_take && src == cisbc_pkg::CISBC_SRC_R75))
				r75_latch_reg <= 1'b0;
		end
	end

	// nonmaskable needs an edge and then a held level; served once per edge
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			nmi_prev_reg <= 1'b0;
			nmi_armed_reg <= 1'b0;
			nmi_pend_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			nmi_prev_reg <= nmi_s;
			nmi_armed_reg <= nmi_s && !nmi_prev_reg;
			if (nmi_armed_reg && nmi_s)
				nmi_pend_reg <= 1'b1;
			else if (!nmi_s || (int_take && src == cisbc_pkg::CISBC_SRC_NMI))
				nmi_pend_reg <= 1'b0;
		end
	end

	// ***************************************************************
	// priority and vectors
	// ***************************************************************
	assign nmi_go = nmi_pend_reg;
	assign r75_go = ie_reg && r75_latch_reg && !mask_reg[2];
	assign r65_go = ie_reg && r65_s && !mask_reg[1];
	assign r55_go = ie_reg && r55_s && !mask_reg[0];
	assign gen_go = ie_reg && gen_s;

	always_comb
	begin
		if (nmi_go)
			src = cisbc_pkg::CISBC_SRC_NMI;
		else if (r75_go)
			src = cisbc_pkg::CISBC_SRC_R75;
		else if (r65_go)
			src = cisbc_pkg::CISBC_SRC_R65;
		else if (r55_go)
			src = cisbc_pkg::CISBC_SRC_R55;
		else if (gen_go)
			src = cisbc_pkg::CISBC_SRC_GEN;
		else
			src = cisbc_pkg::CISBC_SRC_NONE;
	end

	assign int_take = int_poll && (src != cisbc_pkg::CISBC_SRC_NONE);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			int_vector <= `CISBC_VEC_NONE;
		else if (clk_en && int_take)
		begin
			unique case (src)
				cisbc_pkg::CISBC_SRC_NMI: int_vector <= `CISBC_VEC_NMI;
				cisbc_pkg::CISBC_SRC_R75: int_vector <= `CISBC_VEC_75;
				cisbc_pkg::CISBC_SRC_R65: int_vector <= `CISBC_VEC_65;
				cisbc_pkg::CISBC_SRC_R55: int_vector <= `CISBC_VEC_55;
				default: int_vector <= `CISBC_VEC_NONE;
			endcase
		end
	end

	// ***************************************************************
	// general request acknowledge
	// ***************************************************************
	logic ack_reg;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			ack_reg <= 1'b0;
		else if (clk_en)
		begin
			if (int_take && src == cisbc_pkg::CISBC_SRC_GEN)
				ack_reg <= 1'b1;
			else if (int_ack_done)
				ack_reg <= 1'b0;
		end
	end

	assign int_ack_n = ~ack_reg;
	assign hold_pc = ack_reg;
	assign start_addr = `CISBC_START_ADDR;

	// ***************************************************************
	// interrupt enable and masks
	// ***************************************************************
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ie_reg <= 1'b0;
			ie_saved_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (int_take)
			begin
				ie_reg <= 1'b0;
				if (src == cisbc_pkg::CISBC_SRC_NMI)
					ie_saved_reg <= ie_reg;
			end
			else if (int_enable_set)
				ie_reg <= 1'b1;
			else if (int_enable_clr)
				ie_reg <= 1'b0;
			if (mask_read_instruction)
				ie_saved_reg <= ie_reg;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			mask_reg <= `CISBC_MASK_RST;
		else if (clk_en && mask_set_instruction && working_register_a[`CISBC_SET_MASK_EN])
			mask_reg <= working_register_a[2:0];
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			sod_reg <= 1'b0;
		else if (clk_en && mask_set_instruction && working_register_a[`CISBC_SET_SERIAL_EN])
			sod_reg <= working_register_a[`CISBC_SET_SERIAL_DATA];
	end

	assign serial_output_bit = sod_reg;

	// ***************************************************************
	// mask read
	// ***************************************************************
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			mask_read_data <= 8'h00;
		else if (clk_en && mask_read_instruction)
			mask_read_data <= {sid_s, r75_latch_reg, r65_s, r55_s,
				ie_saved_reg | ie_reg, mask_reg};
	end

	// ***************************************************************
	// status codes
	// ***************************************************************
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			status_code_high <= 1'b0;
			status_code_low <= 1'b0;
		end
		else if (clk_en && latch_strobe)
		begin
			status_code_high <= cycle_kind[1];
			status_code_low <= cycle_kind[0];
		end
	end

	// ***************************************************************
	// bus hold
	// ***************************************************************
	logic grant_reg;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			grant_reg <= 1'b0;
		else if (clk_en)
		begin
			if (hold_s && cycle_end)
				grant_reg <= 1'b1;
			else if (!hold_s)
				grant_reg <= 1'b0;
		end
	end

	assign bus_grant_out = grant_reg;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			bus_out <= '{addr: 16'h0000, data: 8'h00, rd_n: 1'b1, wr_n: 1'b1, io_m: 1'b0};
		else if (clk_en)
			bus_out <= bus_drive;
	end

	assign bus_oe = ~grant_reg;
	assign bus_data_oe = grant_reg ? 8'h00 : {8{~bus_drive.wr_n}};

	// ***************************************************************
	// flags
	// ***************************************************************
	cisbc_flags u_flags
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.alu_update(alu_update),
		.alu_sub(alu_sub),
		.alu_a(alu_a),
		.alu_b(alu_b),
		.alu_cin(alu_cin),
		.cond_sel(cond_sel),
		.flags(flags),
		.alu_result(alu_result),
		.cond_true(cond_true)
	);

endmodule : cisbc_ctrl

// ===== sim/cisbc_partner.sv
/* partner model: interrupt sources, serial source and dma master.
 * assumes the bench moves the command levels just after clock edges. */
`timescale 1ns/1ps
module cisbc_partner
(
	input wire logic nmi_go,
	input wire logic [3:0] src_lvl,
	input wire logic sid_val,
	input wire logic dma_go,
	output logic nmi_in,
	output logic restart_75_in,
	output logic restart_65_in,
	output logic restart_55_in,
	output logic general_interrupt_request,
	output logic serial_input_bit,
	output logic bus_request
);
	/**********/
	// pin drivers
	/**********/
	// clean rise, then held high while commanded
	assign nmi_in = nmi_go;
	assign {restart_75_in, restart_65_in, restart_55_in, general_interrupt_request} = src_lvl;
	assign serial_input_bit = sid_val;
	// request stays up until the bench ends the transfer
	assign bus_request = dma_go;
endmodule : cisbc_partner

// ===== sim/cisbc_chk.sv
/* checker: port relations of cisbc_ctrl.
 * assumes it is bound into cisbc_ctrl; one clock domain. */
`timescale 1ns/1ps
module cisbc_chk
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic clk_out,
	input wire logic latch_strobe,
	input wire cisbc_pkg::cisbc_cycle_t cycle_kind,
	input wire logic status_code_high,
	input wire logic status_code_low,
	input wire logic bus_grant_out,
	input wire logic bus_oe,
	input wire logic [7:0] bus_data_oe,
	input wire logic mask_set_instruction,
	input wire logic mask_read_instruction,
	input wire logic [7:0] working_register_a,
	input wire logic [7:0] mask_read_data,
	input wire logic serial_output_bit,
	input wire logic alu_update,
	input wire logic alu_sub,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic alu_cin,
	input wire logic [2:0] cond_sel,
	input wire cisbc_pkg::cisbc_flags_t flags,
	input wire logic [7:0] alu_result,
	input wire logic cond_true
);
	/**********/
	// relations
	/**********/
	logic [8:0] sum_c;
	logic [4:0] nib_c;
	logic [3:0] fv;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	assign sum_c = alu_sub ? {1'b0, alu_a} - alu_b - alu_cin : {1'b0, alu_a} + alu_b + alu_cin;
	assign nib_c = alu_sub ? {1'b0, alu_a[3:0]} - alu_b[3:0] - alu_cin
		: {1'b0, alu_a[3:0]} + alu_b[3:0] + alu_cin;
	assign fv = {flags.sign, flags.parity, flags.carry, flags.zero};
	sequence s_mask_set;
		clk_en && mask_set_instruction && working_register_a[3];
	endsequence
	sequence s_mask_read;
		clk_en && mask_read_instruction;
	endsequence
	sequence s_serial_set;
		clk_en && mask_set_instruction && working_register_a[6];
	endsequence
	a_grant_float: assert property (bus_grant_out |-> !bus_oe && bus_data_oe == 8'h00)
		else $error("bus driven while granted");
	a_clock_half: assert property (clk_en |=> clk_out != $past(clk_out))
		else $error("clock out not halved");
	a_status_latch: assert property (clk_en && latch_strobe |=>
		{status_code_high, status_code_low} == $past(cycle_kind))
		else $error("status code wrong");
	a_mask_roundtrip: assert property (s_mask_set ##1 s_mask_read |=>
		mask_read_data[2:0] == $past(working_register_a[2:0], 2))
		else $error("mask not read back");
	a_serial_out: assert property (s_serial_set |=>
		serial_output_bit == $past(working_register_a[7]))
		else $error("serial out not written");
	a_serial_kept: assert property (
		!(mask_set_instruction && working_register_a[6]) |=> $stable(serial_output_bit))
		else $error("serial out changed");
	a_sign_zero: assert property (clk_en && alu_update |=>
		alu_result == $past(sum_c[7:0])
		&& flags.sign == alu_result[7] && flags.zero == (alu_result == 8'h00))
		else $error("sign or zero wrong");
	a_parity_even: assert property (clk_en && alu_update |=>
		flags.parity == ~^alu_result)
		else $error("parity wrong");
	a_carry_out: assert property (clk_en && alu_update |=>
		flags.carry == $past(sum_c[8]) && flags.aux_carry == $past(nib_c[4]))
		else $error("carry wrong");
	a_cond_eval: assert property (cond_true == (fv[cond_sel[2:1]] == cond_sel[0]))
		else $error("condition wrong");
	a_reset_clear: assert property ($fell(sys_rst) |-> !bus_grant_out && bus_oe)
		else $error("grant after reset");
	a_freeze_hold: assert property (!clk_en |=>
		$stable(clk_out) && $stable(serial_output_bit) && $stable(flags))
		else $error("state moved while frozen");
endmodule : cisbc_chk

bind cisbc_ctrl cisbc_chk chk_i (.core_clk, .sys_rst, .clk_en, .clk_out, .latch_strobe,
	.cycle_kind, .status_code_high, .status_code_low, .bus_grant_out, .bus_oe, .bus_data_oe,
	.mask_set_instruction, .mask_read_instruction, .working_register_a, .mask_read_data,
	.serial_output_bit, .alu_update, .alu_sub, .alu_a, .alu_b, .alu_cin, .cond_sel, .flags,
	.alu_result, .cond_true);

// ===== sim/cisbc_ctrl_bench.sv
/* bench for cisbc_ctrl: random flag and mask traffic, interrupt,
 * status and bus-hold corner cases.
 * assumes partner and checker compile first. */
`timescale 1ns/1ps
module cisbc_ctrl_bench;
	/**********/
	// stimulus and checks
	/**********/
	logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, int_poll = 1'b0, cycle_end = 1'b0;
	logic int_enable_set = 1'b0, int_enable_clr = 1'b0, int_ack_done = 1'b0;
	logic mask_read_instruction = 1'b0, mask_set_instruction = 1'b0, latch_strobe = 1'b0;
	logic alu_update = 1'b0, alu_sub = 1'b0, alu_cin = 1'b0, nmi_go = 1'b0, dma_go = 1'b0;
	logic [7:0] working_register_a = 8'h00, alu_a = 8'h00, alu_b = 8'h00;
	logic [3:0] src_lvl = 4'h0;
	logic [2:0] cond_sel = 3'h0;
	logic sid_val = 1'b0;
	cisbc_pkg::cisbc_cycle_t cycle_kind = cisbc_pkg::CISBC_CYC_HALT;
	cisbc_pkg::cisbc_bus_t bus_drive = '0;
	cisbc_pkg::cisbc_bus_t bus_out;
	cisbc_pkg::cisbc_flags_t flags;
	wire logic nmi_in, restart_75_in, restart_65_in, restart_55_in, general_interrupt_request;
	wire logic serial_input_bit, bus_request;
	logic clk_out, int_take, int_ack_n, hold_pc, serial_output_bit, bus_grant_out, bus_oe;
	logic status_code_high, status_code_low, cond_true;
	logic [7:0] int_vector, mask_read_data, bus_data_oe, alu_result;
	logic [15:0] start_addr;
	logic [31:0] rv;
	logic [12:0] e;
	logic [3:0] fv;
	logic [2:0] mask_m = 3'h7;
	logic sod_m = 1'b0;
	int fail_count = 0, n_tests = 0, seed = 32'hdaad6735, i, k;

	cisbc_partner partner (.nmi_go, .src_lvl, .sid_val, .dma_go, .nmi_in, .restart_75_in,
		.restart_65_in, .restart_55_in, .general_interrupt_request, .serial_input_bit,
		.bus_request);
	cisbc_ctrl uut (.core_clk, .sys_rst, .clk_en, .clk_out, .nmi_in, .restart_75_in,
		.restart_65_in, .restart_55_in, .general_interrupt_request, .int_poll, .int_enable_set,
		.int_enable_clr, .int_take, .int_vector, .int_ack_n, .int_ack_done, .hold_pc,
		.start_addr, .mask_read_instruction, .mask_set_instruction, .working_register_a,
		.mask_read_data, .serial_input_bit, .serial_output_bit, .bus_request, .cycle_end,
		.bus_grant_out, .latch_strobe, .cycle_kind, .status_code_high, .status_code_low,
		.bus_drive, .bus_out, .bus_oe, .bus_data_oe, .alu_update, .alu_sub, .alu_a, .alu_b,
		.alu_cin, .cond_sel, .flags, .alu_result, .cond_true);

	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) cycle_end <= ~cycle_end;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test();
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic mset(input logic [7:0] a);
		@(posedge core_clk);
		working_register_a <= a;
		mask_set_instruction <= 1'b1;
		mask_m = a[3] ? a[2:0] : mask_m;
		sod_m = a[6] ? a[7] : sod_m;
		@(posedge core_clk);
		mask_set_instruction <= 1'b0;
	endtask : mset

	task automatic mread();
		mask_read_instruction <= 1'b1;
		@(posedge core_clk);
		mask_read_instruction <= 1'b0;
		#1;
	endtask : mread

	task automatic ie_set(input logic on);
		@(posedge core_clk);
		int_enable_set <= on;
		int_enable_clr <= ~on;
		@(posedge core_clk);
		int_enable_set <= 1'b0;
		int_enable_clr <= 1'b0;
	endtask : ie_set

	task automatic poll(input logic t, input logic [7:0] v);
		@(posedge core_clk);
		int_poll <= 1'b1;
		#1 chk(int_take, t);
		@(posedge core_clk);
		int_poll <= 1'b0;
		#1 if (t) chk(int_vector, v);
	endtask : poll

	task automatic wait_grant(input logic v);
		k = 0;
		while (bus_grant_out !== v && k < 20)
		begin
			@(posedge core_clk);
			k++;
		end
		#1 chk(bus_grant_out, v);
		if (bus_grant_out !== v) finish_test();
	endtask : wait_grant

	task automatic edge_75();
		src_lvl <= 4'h8;
		cyc(3);
		src_lvl <= 4'h0;
		cyc(4);
	endtask : edge_75

	function automatic logic [12:0] alu_exp(input logic [17:0] r);
		logic [8:0] s;
		logic [4:0] h;
		s = r[16] ? {1'b0, r[7:0]} - r[15:8] - r[17] : {1'b0, r[7:0]} + r[15:8] + r[17];
		h = r[16] ? {1'b0, r[3:0]} - r[11:8] - r[17] : {1'b0, r[3:0]} + r[11:8] + r[17];
		alu_exp = {s[7], s[7:0] == 8'h00, h[4], ~^s[7:0], s[8], s[7:0]};
	endfunction : alu_exp

	initial
	begin
		cyc(8);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		#1 chk({bus_grant_out, start_addr}, 17'h0);
		mread();
		chk(mask_read_data, 8'h07);
		for (i = 0; i < 4; i++)
		begin
			@(posedge core_clk);
			cycle_kind <= cisbc_pkg::cisbc_cycle_t'(i[1:0]);
			latch_strobe <= 1'b1;
			@(posedge core_clk);
			latch_strobe <= 1'b0;
			#1 chk({status_code_high, status_code_low}, i[1:0]);
		end
		$display("status done");
		for (i = 0; i < 64; i++)
		begin
			rv = (i == 0) ? 32'h0000_01FF : (i == 1) ? 32'h0001_0100 : $random(seed);
			@(posedge core_clk);
			{cond_sel, alu_cin, alu_sub, alu_b, alu_a} <= rv[20:0];
			bus_drive <= rv[26:0];
			alu_update <= 1'b1;
			@(posedge core_clk);
			alu_update <= 1'b0;
			e = alu_exp(rv[17:0]);
			fv = {e[12], e[9], e[8], e[11]};
			#1 chk({flags, alu_result}, e);
			chk(cond_true, fv[rv[20:19]] == rv[18]);
			chk(bus_out, rv[26:0]);
			chk({bus_oe, bus_data_oe}, {1'b1, {8{~rv[1]}}});
		end
		$display("flags done");
		for (i = 0; i < 16; i++)
		begin
			rv = $random(seed);
			sid_val <= rv[8];
			cyc(3);
			mset(rv[7:0]);
			mread();
			chk(mask_read_data, {rv[8], 4'h0, mask_m});
			chk(serial_output_bit, sod_m);
		end
		$display("mask done");
		mset(8'h18);
		src_lvl <= 4'h7;
		cyc(4);
		ie_set(1'b1);
		poll(1'b1, 8'h34);
		mset(8'h0A);
		ie_set(1'b1);
		poll(1'b1, 8'h2C);
		mset(8'h0B);
		ie_set(1'b1);
		poll(1'b1, 8'h00);
		chk({int_ack_n, hold_pc}, 2'h1);
		int_ack_done <= 1'b1;
		@(posedge core_clk);
		int_ack_done <= 1'b0;
		#1 chk({int_ack_n, hold_pc}, 2'h2);
		ie_set(1'b0);
		poll(1'b0, 8'h00);
		src_lvl <= 4'h0;
		edge_75();
		ie_set(1'b1);
		poll(1'b1, 8'h3C);
		mset(8'h0C);
		edge_75();
		ie_set(1'b1);
		poll(1'b0, 8'h00);
		mread();
		chk(mask_read_data[6:4], 3'h4);
		mset(8'h1F);
		mread();
		chk(mask_read_data[6:4], 3'h0);
		$display("interrupts done");
		nmi_go <= 1'b1;
		cyc(6);
		poll(1'b1, 8'h24);
		mread();
		chk(mask_read_data[3], 1'b1);
		poll(1'b0, 8'h00);
		nmi_go <= 1'b0;
		cyc(4);
		nmi_go <= 1'b1;
		cyc(6);
		poll(1'b1, 8'h24);
		$display("nonmaskable done");
		dma_go <= 1'b1;
		wait_grant(1'b1);
		chk({bus_oe, bus_data_oe}, 9'h000);
		dma_go <= 1'b0;
		wait_grant(1'b0);
		chk(bus_oe, 1'b1);
		$display("hold done");
		// frozen clock enable: a pending serial write must not land
		@(posedge core_clk);
		clk_en <= 1'b0;
		working_register_a <= {~sod_m, 7'h40};
		mask_set_instruction <= 1'b1;
		#1 k = clk_out;
		cyc(3);
		#1 chk({clk_out, serial_output_bit}, {k[0], sod_m});
		@(posedge core_clk);
		clk_en <= 1'b1;
		mask_set_instruction <= 1'b0;
		$display("freeze done");
		finish_test();
	end
endmodule : cisbc_ctrl_bench
